// [src/uirq_pkg.sv]
// constants for the uart interrupt and register map block
package uirq_pkg;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_FIFO_FRAMING_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RAW = 8'h14;
  localparam logic [7:0] OFS_EN = 8'h18;
  localparam logic [7:0] OFS_MIS = 8'h1c;
  localparam logic [7:0] OFS_RES = 8'h20;
  localparam logic [7:0] OFS_EIC = 8'h24;
  localparam logic [7:0] OFS_DMA = 8'h28;
  // irq bit positions: framing, parity, break, overrun, rx, tx, modem, timeout
  localparam int B_FE = 0;
  localparam int B_PE = 1;
  localparam int B_BE = 2;
  localparam int B_OE = 3;
  localparam int B_RX = 4;
  localparam int B_TX = 5;
  localparam int B_MI = 6;
  localparam int B_RT = 7;
  // port_control bits
  localparam int C_EN = 0;
  localparam int C_IR_BLANKING_DISABLE = 1;
  localparam int C_LBE = 2;
  // line_status bits
  localparam int S_RXFE = 0;
  localparam int S_TXFE = 1;
  localparam logic [4:0] RX_HALF = 5'h08;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// [src/uirq_core.sv]
// uart interrupt aggregation, loopback steering and apb register map
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - enable bit 1 enables, 0 disables source
// - masked status is raw AND enable
// - combined irq ORs all masked bits
// - error irq ORs four masked error bits
// - instance with HAS_MODEM 0 drops modem source
// - error irq is its own output
// - errored character sets raw error bit
// - data error flags cleared only on new character
// - loopback routes outputs back to inputs
// - blanking disable bit 1 off, 0 on
// - registers decoded at fixed word offsets
// - data read returns char and four flags
// - data write takes low byte only
// - modem eoi write clears only modem bit
// - rx irq set at eight, clear at seven
module uirq_core #(
  parameter bit HAS_MODEM = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic [3:0] rx_char_err,
  input wire logic [4:0] rx_fifo_level,
  input wire logic tx_space_level,
  input wire logic rx_timeout_event,
  input wire logic modem_change_event,
  output logic tx_char_valid,
  output logic [7:0] tx_char,
  output logic rx_char_read,
  input wire logic serial_tx_core,
  input wire logic infrared_tx_core,
  input wire logic serial_in,
  input wire logic infrared_in,
  output logic serial_out,
  output logic infrared_out,
  output logic serial_rx_core,
  output logic infrared_rx_core,
  output logic ir_blanking_on,
  output logic port_enable,
  output logic combined_irq_out,
  output logic error_irq_out
);
  typedef struct packed {
    logic [31:0] rdata;
    logic [11:0] data;
    logic [6:0] fifo_framing_control;
    logic [15:0] baud;
    logic [2:0] ctrl;
    logic [7:0] raw;
    logic [7:0] irq_enable_mask;
    logic [3:0] rx_err;
    logic [1:0] dma;
    logic tx_v;
    logic [7:0] tx_d;
    logic rd_pulse;
    logic irq;
    logic err;
    logic s1a;
    logic s1b;
    logic s2a;
    logic s2b;
  } uirq_state_s;

  uirq_state_s q, d;
  logic access;
  logic wr;
  logic rd_setup;
  logic [7:0] masked_irq_status;
  logic [7:0] src_mask;
  logic [7:0] ev;

  assign access = psel && penable;
  assign wr = access && pwrite;
  // read data is captured in the setup cycle so prdata leaves a flop
  assign rd_setup = psel && !penable && !pwrite;
  // modem source excluded on the instance lacking modem inputs
  assign src_mask = HAS_MODEM ? 8'hff : 8'hbf;

  // one gate per source; the mask keeps unused sources out of both outputs
  for (genvar gi = 0; gi < 8; gi++) begin : g_mask
    assign masked_irq_status[gi] = q.raw[gi] & q.irq_enable_mask[gi] & src_mask[gi];
  end

  always_comb begin
    d = q;
    d.rd_pulse = 1'b0;
    d.tx_v = 1'b0;
    // pin inputs pass two flops before any use
    d.s1a = serial_in;
    d.s1b = q.s1a;
    d.s2a = infrared_in;
    d.s2b = q.s2a;
    // level sources follow the fifo state
    d.raw[uirq_pkg::B_RX] = (rx_fifo_level >= uirq_pkg::RX_HALF);
    d.raw[uirq_pkg::B_TX] = tx_space_level;
    ev = '0;
    ev[uirq_pkg::B_RT] = rx_timeout_event;
    ev[uirq_pkg::B_MI] = modem_change_event & HAS_MODEM;

    if (rx_char_valid) begin
      // new character replaces flags; reads never clear them
      d.data = {rx_char_err, rx_char};
      // flags come as {break, overrun, parity, framing}; raw bits use their own order
      ev[uirq_pkg::B_FE] = rx_char_err[0];
      ev[uirq_pkg::B_PE] = rx_char_err[1];
      ev[uirq_pkg::B_OE] = rx_char_err[2];
      ev[uirq_pkg::B_BE] = rx_char_err[3];
      d.rx_err = q.rx_err | rx_char_err;
    end
    if (wr) begin
      case (paddr)
        uirq_pkg::OFS_DATA: begin
          d.tx_v = 1'b1;
          d.tx_d = pwdata[7:0];
        end
        uirq_pkg::OFS_FIFO_FRAMING_CONTROL: d.fifo_framing_control = pwdata[6:0];
        uirq_pkg::OFS_BAUD: d.baud = pwdata[15:0];
        uirq_pkg::OFS_CTRL: d.ctrl = pwdata[2:0];
        uirq_pkg::OFS_RAW: d.raw[uirq_pkg::B_MI] = 1'b0;
        uirq_pkg::OFS_EN: d.irq_enable_mask = pwdata[7:0];
        uirq_pkg::OFS_RES: d.rx_err = 4'h0;
        uirq_pkg::OFS_EIC: begin
          d.raw[3:0] = q.raw[3:0] & ~pwdata[3:0];
          d.rx_err = 4'h0;
        end
        uirq_pkg::OFS_DMA: d.dma = pwdata[1:0];
        default: d.dma = d.dma; // masked status and unmapped: no effect
      endcase
    end
    // set wins over clear for event bits
    d.raw[uirq_pkg::B_RT] = d.raw[uirq_pkg::B_RT] | ev[uirq_pkg::B_RT];
    d.raw[uirq_pkg::B_MI] = d.raw[uirq_pkg::B_MI] | ev[uirq_pkg::B_MI];
    d.raw[3:0] = d.raw[3:0] | ev[3:0];
    d.rx_err = d.rx_err | (rx_char_valid ? rx_char_err : 4'h0);

    // a source moving during the access cycle shows on the next read
    d.rd_pulse = access && !pwrite && (paddr == uirq_pkg::OFS_DATA);
    if (rd_setup) begin
      case (paddr)
        uirq_pkg::OFS_DATA: d.rdata = {20'h0, q.data};
        uirq_pkg::OFS_FIFO_FRAMING_CONTROL: d.rdata = {25'h0, q.fifo_framing_control};
        uirq_pkg::OFS_BAUD: d.rdata = {16'h0, q.baud};
        uirq_pkg::OFS_CTRL: d.rdata = {29'h0, q.ctrl};
        uirq_pkg::OFS_STAT: d.rdata = {30'h0, tx_space_level, rx_fifo_level == 5'h00};
        uirq_pkg::OFS_RAW: d.rdata = {24'h0, q.raw};
        uirq_pkg::OFS_EN: d.rdata = {24'h0, q.irq_enable_mask};
        uirq_pkg::OFS_MIS: d.rdata = {24'h0, masked_irq_status};
        uirq_pkg::OFS_RES: d.rdata = {28'h0, q.rx_err};
        uirq_pkg::OFS_DMA: d.rdata = {30'h0, q.dma};
        default: d.rdata = uirq_pkg::RST_ZERO;
      endcase
    end
    d.irq = |masked_irq_status;
    d.err = |masked_irq_status[3:0];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // zero wait states: the word captured at setup stands through the access cycle
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tx_char_valid = q.tx_v;
  assign tx_char = q.tx_d;
  assign rx_char_read = q.rd_pulse;
  assign port_enable = q.ctrl[uirq_pkg::C_EN];
  assign ir_blanking_on = ~q.ctrl[uirq_pkg::C_IR_BLANKING_DISABLE];
  // loopback: drivers return to receiver, serial line held idle high, infrared line held low
  assign serial_rx_core = q.ctrl[uirq_pkg::C_LBE] ? serial_tx_core : q.s1b;
  assign infrared_rx_core = q.ctrl[uirq_pkg::C_LBE] ? infrared_tx_core : q.s2b;
  assign serial_out = q.ctrl[uirq_pkg::C_LBE] ? 1'b1 : serial_tx_core;
  assign infrared_out = q.ctrl[uirq_pkg::C_LBE] ? 1'b0 : infrared_tx_core;
  assign combined_irq_out = q.irq;
  assign error_irq_out = q.err;

  a_mask_and: assert property (@(posedge clk) disable iff (!resetn)
    (paddr == uirq_pkg::OFS_MIS && access && !pwrite) |->
      prdata[7:0] == $past(masked_irq_status))
    else $error("masked status mismatch");
  a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> combined_irq_out == |$past(masked_irq_status))
    else $error("combined irq wrong");
  a_err_level: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> error_irq_out == |$past(masked_irq_status[3:0]))
    else $error("error irq wrong");
  a_modem_out: assert property (@(posedge clk) disable iff (!resetn)
    !HAS_MODEM |-> !masked_irq_status[uirq_pkg::B_MI])
    else $error("modem source leaked");
  a_err_set: assert property (@(posedge clk) disable iff (!resetn)
    (rx_char_valid && rx_char_err[0]) |=> q.raw[uirq_pkg::B_FE])
    else $error("framing bit not set");
  a_flag_keep: assert property (@(posedge clk) disable iff (!resetn)
    !rx_char_valid |=> q.data == $past(q.data))
    else $error("data flags changed without char");
  a_loop_path: assert property (@(posedge clk) disable iff (!resetn)
    q.ctrl[uirq_pkg::C_LBE] |-> serial_rx_core == serial_tx_core)
    else $error("loopback not routed");
  a_eoi_only: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_RAW && !rx_char_valid && !modem_change_event
      && !rx_timeout_event) |=> !q.raw[uirq_pkg::B_MI] && q.raw[3:0] == $past(q.raw[3:0]))
    else $error("eoi touched other bits");
  a_rx_half: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> q.raw[uirq_pkg::B_RX] == ($past(rx_fifo_level) >= uirq_pkg::RX_HALF))
    else $error("rx level irq wrong");
  a_reset_low: assert property (@(posedge clk)
    !$past(resetn) |-> !combined_irq_out && !error_irq_out)
    else $error("irq high after reset");

  // enables and masking
  a_en_write: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_EN)
      |=> q.irq_enable_mask == $past(pwdata[7:0]))
    else $error("enable write lost");

  a_en_read: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_EN)
      |-> prdata[7:0] == q.irq_enable_mask)
    else $error("enable readback wrong");

  a_mask_off: assert property (@(posedge clk) disable iff (!resetn)
    (q.irq_enable_mask == 8'h00)
      |-> masked_irq_status == 8'h00)
    else $error("disabled source visible");

  a_tx_level: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn)
      |-> q.raw[uirq_pkg::B_TX] == $past(tx_space_level))
    else $error("tx level irq wrong");

  a_rt_set: assert property (@(posedge clk) disable iff (!resetn)
    rx_timeout_event
      |=> q.raw[uirq_pkg::B_RT])
    else $error("timeout bit not set");

  a_raw_read: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_RAW)
      |-> prdata[7:0] == $past(q.raw))
    else $error("raw readback wrong");

  // output lines
  a_err_sub: assert property (@(posedge clk) disable iff (!resetn)
    error_irq_out
      |-> combined_irq_out)
    else $error("error irq without combined irq");

  a_err_only: assert property (@(posedge clk) disable iff (!resetn)
    (masked_irq_status[7:4] != 4'h0 && masked_irq_status[3:0] == 4'h0)
      |=> combined_irq_out && !error_irq_out)
    else $error("error irq follows non-error source");

  a_modem_raw: assert property (@(posedge clk) disable iff (!resetn)
    !HAS_MODEM
      |-> !q.raw[uirq_pkg::B_MI])
    else $error("modem raw bit set");

  // error capture, each flag to its own raw bit
  a_par_set: assert property (@(posedge clk) disable iff (!resetn)
    (rx_char_valid && rx_char_err[1])
      |=> q.raw[uirq_pkg::B_PE])
    else $error("parity bit not set");

  a_ovr_set: assert property (@(posedge clk) disable iff (!resetn)
    (rx_char_valid && rx_char_err[2])
      |=> q.raw[uirq_pkg::B_OE])
    else $error("overrun bit not set");

  a_brk_set: assert property (@(posedge clk) disable iff (!resetn)
    (rx_char_valid && rx_char_err[3])
      |=> q.raw[uirq_pkg::B_BE])
    else $error("break bit not set");

  a_eic_clear: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_EIC && !rx_char_valid)
      |=> (q.raw[3:0] & $past(pwdata[3:0])) == 4'h0)
    else $error("error clear ignored");

  a_flag_load: assert property (@(posedge clk) disable iff (!resetn)
    rx_char_valid
      |=> q.data == $past({rx_char_err, rx_char}))
    else $error("character not captured");

  // loopback and pins
  a_loop_ir: assert property (@(posedge clk) disable iff (!resetn)
    q.ctrl[uirq_pkg::C_LBE]
      |-> infrared_rx_core == infrared_tx_core)
    else $error("infrared loopback not routed");

  a_pin_path: assert property (@(posedge clk) disable iff (!resetn)
    ($past(resetn) && $past(resetn, 2) && !q.ctrl[uirq_pkg::C_LBE])
      |-> serial_rx_core == $past(serial_in, 2))
    else $error("receiver not fed from pin");

  a_out_loop: assert property (@(posedge clk) disable iff (!resetn)
    q.ctrl[uirq_pkg::C_LBE]
      |-> serial_out && !infrared_out)
    else $error("pins not idle in loopback");

  a_out_norm: assert property (@(posedge clk) disable iff (!resetn)
    !q.ctrl[uirq_pkg::C_LBE]
      |-> serial_out == serial_tx_core && infrared_out == infrared_tx_core)
    else $error("pins not driven by transmitter");

  a_blank_set: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_CTRL)
      |=> ir_blanking_on == !$past(pwdata[uirq_pkg::C_IR_BLANKING_DISABLE]))
    else $error("blanking control wrong");

  // register map
  a_ctrl_en: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_CTRL)
      |=> port_enable == $past(pwdata[uirq_pkg::C_EN]))
    else $error("port enable not written");

  a_unmapped: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr > uirq_pkg::OFS_DMA)
      |-> prdata == uirq_pkg::RST_ZERO)
    else $error("reserved offset not zero");

  a_res_read: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_RES)
      |-> prdata[31:4] == 28'h0)
    else $error("error status upper bits set");

  a_stat_read: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_STAT)
      |-> prdata[31:2] == 30'h0)
    else $error("status upper bits set");

  a_data_high: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_DATA)
      |-> prdata[31:12] == 20'h0)
    else $error("data upper bits set");

  a_data_read: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_DATA)
      |-> prdata[11:0] == $past(q.data))
    else $error("data readback wrong");

  a_rd_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (access && !pwrite && paddr == uirq_pkg::OFS_DATA)
      |=> rx_char_read)
    else $error("read pulse missing");

  a_tx_low: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_DATA)
      |=> tx_char_valid && tx_char == $past(pwdata[7:0]))
    else $error("transmit byte wrong");

  a_mi_set: assert property (@(posedge clk) disable iff (!resetn)
    (modem_change_event && HAS_MODEM)
      |=> q.raw[uirq_pkg::B_MI])
    else $error("modem bit not set");

  a_mis_ro: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == uirq_pkg::OFS_MIS)
      |=> q.irq_enable_mask == $past(q.irq_enable_mask))
    else $error("masked status write took effect");
endmodule
`default_nettype wire

// [tb/uirq_far_model.sv]
// far side model: receiver hands in characters, transmitter latches what leaves
`timescale 1ns/10ps
`default_nettype none
module uirq_far_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] send_char,
  input wire logic [3:0] send_err,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char,
  output logic rx_char_valid = 1'b0,
  output logic [7:0] rx_char = 8'h00,
  output logic [3:0] rx_char_err = 4'h0,
  output logic [7:0] last_tx = 8'h00
);
  always_ff @(posedge clk) begin
    rx_char_valid <= send;
    // outside a pulse the lines toggle, so a stale character is never trusted
    rx_char <= send ? send_char : ~rx_char;
    rx_char_err <= send ? send_err : ~rx_char_err;
    if (tx_char_valid) begin
      last_tx <= tx_char;
    end
  end
endmodule
`default_nettype wire

// [tb/test_uart_interrupt_and_register_map.sv]
// self-checking bench for the uart interrupt and register map block
`timescale 1ns/10ps
`default_nettype none
module test_uart_interrupt_and_register_map;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0;
  logic tx_space_level = 1'b0, rx_timeout_event = 1'b0, modem_change_event = 1'b0;
  logic serial_tx_core = 1'b0, infrared_tx_core = 1'b0, serial_in = 1'b1, infrared_in = 1'b0;
  logic [7:0] paddr = 8'h00, send_char = 8'h00, tx_char, rx_char, last_tx, en;
  logic [31:0] pwdata = 32'h0, prdata, rd, s, lfsr = 32'hf180aa40, rd_nm, prdata_nm;
  logic irq_nm, err_nm;
  logic [3:0] send_err = 4'h0, rx_char_err, e;
  logic [4:0] rx_fifo_level = 5'h00;
  logic pready, pslverr, rx_char_valid, tx_char_valid, rx_char_read, serial_out, infrared_out;
  logic serial_rx_core, infrared_rx_core, ir_blanking_on, port_enable, combined_irq_out;
  logic error_irq_out;
  int err_count = 0, comparisons = 0, cycles = 0, reads = 0;
  uirq_core uirq_core_inst (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_char_valid, .rx_char, .rx_char_err, .rx_fifo_level, .tx_space_level,
    .rx_timeout_event, .modem_change_event, .tx_char_valid, .tx_char, .rx_char_read,
    .serial_tx_core, .infrared_tx_core, .serial_in, .infrared_in, .serial_out, .infrared_out,
    .serial_rx_core, .infrared_rx_core, .ir_blanking_on, .port_enable, .combined_irq_out,
    .error_irq_out);
  uirq_far_model uirq_far_model_inst (.clk, .send, .send_char, .send_err, .tx_char_valid,
    .tx_char, .rx_char_valid, .rx_char, .rx_char_err, .last_tx);
  // instance without modem inputs shares every input of the main one
  uirq_core #(.HAS_MODEM(1'b0)) uirq_core_nomodem_inst (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(prdata_nm), .pready(), .pslverr(), .rx_char_valid,
    .rx_char, .rx_char_err, .rx_fifo_level, .tx_space_level, .rx_timeout_event,
    .modem_change_event, .tx_char_valid(), .tx_char(), .rx_char_read(), .serial_tx_core,
    .infrared_tx_core, .serial_in, .infrared_in, .serial_out(), .infrared_out(),
    .serial_rx_core(), .infrared_rx_core(), .ir_blanking_on(), .port_enable(),
    .combined_irq_out(irq_nm), .error_irq_out(err_nm));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_char_read) begin
      reads <= reads + 1;
    end
    if (cycles == 8000) begin
      err_count++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction
  // raw bits: framing, parity, break, overrun, rx level, tx space, modem, timeout
  function automatic logic [7:0] exp_raw(input logic rt, input logic mi, input logic [3:0] er);
    return {rt, mi, tx_space_level, rx_fifo_level >= 5'h08, er[2], er[3], er[1], er[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    rd_nm = prdata_nm;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_irq(input logic [7:0] r, input logic [7:0] m);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, {24'h0, r});
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, {24'h0, r & m});
    chk(rd_nm, {24'h0, r & m & 8'hbf});
    chk({30'h0, combined_irq_out, error_irq_out}, {30'h0, |(r & m), |(r[3:0] & m[3:0])});
    chk({30'h0, irq_nm, err_nm}, {30'h0, |(r & m & 8'hbf), |(r[3:0] & m[3:0])});
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({30'h0, combined_irq_out, error_irq_out}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h0c, 32'h1);
    chk({31'h0, port_enable}, 32'h1);
    $display("done: reset");
    for (int i = 0; i < 40; i++) begin
      s = rnd();
      en = (i == 3) ? 8'hff : s[7:0];
      e = (i == 3) ? 4'hf : s[11:8];
      apb(1'b1, 8'h24, 32'hf);
      apb(1'b1, 8'h14, 32'h0);
      send <= 1'b1;
      send_char <= s[23:16];
      send_err <= e;
      rx_fifo_level <= (i == 0) ? 5'h08 : (i == 1) ? 5'h07 : (i == 2) ? 5'h10 : {1'b0, s[27:24]};
      tx_space_level <= s[29];
      modem_change_event <= s[30];
      @(posedge clk);
      send <= 1'b0;
      modem_change_event <= 1'b0;
      apb(1'b1, 8'h18, {24'h0, en});
      apb(1'b1, 8'h1c, 32'hffffffff);
      chk_irq(exp_raw(1'b0, s[30], e), en);
      apb(1'b0, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {20'h0, e, s[23:16]});
    end
    rx_timeout_event <= 1'b1;
    modem_change_event <= 1'b1;
    @(posedge clk);
    rx_timeout_event <= 1'b0;
    modem_change_event <= 1'b0;
    apb(1'b1, 8'h14, 32'h0fffffff);
    chk_irq(exp_raw(1'b1, 1'b0, e), en);
    $display("done: interrupts");
    apb(1'b1, 8'h00, 32'hffffff5a);
    @(posedge clk);
    chk({24'h0, last_tx}, 32'h5a);
    // dma register at the last offset keeps only its two bits
    apb(1'b1, 8'h28, 32'hffffffff);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h04 + 8'h04 * i[7:0], 32'hffffffff);
      apb(1'b0, 8'h04 + 8'h04 * i[7:0], 32'h0);
      chk(rd, (i == 0) ? 32'h7f : (i == 1) ? 32'hffff : 32'h7);
    end
    $display("done: map");
    // blanking disable and loopback bits go up together; the infrared loop path does not use blanking
    apb(1'b1, 8'h0c, 32'h7);
    chk({31'h0, ir_blanking_on}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      serial_tx_core <= i[0];
      infrared_tx_core <= i[1];
      serial_in <= ~i[0];
      infrared_in <= ~i[1];
      repeat (3) @(posedge clk);
      chk({30'h0, serial_rx_core, infrared_rx_core}, {30'h0, i[0], i[1]});
      chk({30'h0, serial_out, infrared_out}, 32'h2);
    end
    apb(1'b1, 8'h0c, 32'h1);
    repeat (3) @(posedge clk);
    chk({27'h0, ir_blanking_on, serial_rx_core, infrared_rx_core, serial_out, infrared_out},
      32'h13);
    $display("done: loopback");
    chk(reads, 32'd81);
    final_report();
  end
endmodule
`default_nettype wire
